// >>> core/smbus_port_pkg.sv
// Constants, states and timing for the chip-select gated SMBus target port.
//
// What this block does
// - Select high enables the target port.
// - Select low: ignore bus, never drive data.
// - Port keeps running during equalizer standby.
// - Answer only to address 1010110 (byte AC).
// - Data changes only while clock is low.
// - Data falling with clock high starts message.
// - Data rising with clock high ends message.
// - Idle after bus free or clock high limit.
// - Detect clock held low for 25 to 35 ms.
// - Total target clock stretch stays under 2 ms.
// - Ready within 500 ms after power-on reset.
// - Both register write and read supported.
// - Write: address, index, data, each acknowledged low.
// - Read: index, repeated start, address, bytes out until host nack.
package smbus_port_pkg;

    // ----------------------------------------------------------------
    // Addressing
    // ----------------------------------------------------------------
    localparam logic [6:0] TARGET_ADDR7 = 7'h56;
    localparam logic [7:0] TARGET_ADDR_WRITE_BYTE = 8'hAC;

    // ----------------------------------------------------------------
    // Timing, reference clock 100 MHz
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned BUS_FREE_TIME_NS = 4700;
    localparam int unsigned CLOCK_HIGH_PERIOD_US = 50;
    localparam int unsigned CLOCK_LOW_TIMEOUT_MS = 25;
    localparam int unsigned TARGET_STRETCH_TOTAL_MS = 2;
    localparam int unsigned POWER_ON_READY_TIME_MS = 500;
    // Least time: round up
    localparam logic [31:0] BUS_FREE_CYC =
        32'((BUS_FREE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // Longest time: round down
    localparam logic [31:0] CLOCK_HIGH_CYC =
        32'((CLOCK_HIGH_PERIOD_US * 1000) / CLK_PERIOD_NS);
    localparam logic [31:0] CLOCK_LOW_TIMEOUT_CYC =
        32'((CLOCK_LOW_TIMEOUT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ----------------------------------------------------------------
    // Counters and reset values
    // ----------------------------------------------------------------
    localparam logic [3:0] RX_LAST_CNT = 4'h8;
    localparam logic [3:0] TX_LAST_CNT = 4'h7;
    localparam logic [3:0] BIT_CNT_RST = 4'h0;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [7:0] INDEX_STEP = 8'h01;
    localparam logic [31:0] TIMER_CNT_RST = 32'h0;

    // ----------------------------------------------------------------
    // States
    // ----------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_RX   = 6'h02,
        ST_ACK  = 6'h04,
        ST_TX   = 6'h08,
        ST_RACK = 6'h10,
        ST_WAIT = 6'h20
    } port_state_t;

    typedef enum logic [2:0] {
        PH_ADDR  = 3'h1,
        PH_INDEX = 3'h2,
        PH_DATA  = 3'h4
    } byte_phase_t;

endpackage

// >>> core/pin_sync.sv
// Two-flop synchronisers for the bus pins, with one delayed copy for edges.
`timescale 1ns/1ps
`default_nettype none
module pin_sync
    import smbus_port_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [2:0] pin_i,
    output logic [2:0] level_o,
    output logic [2:0] prev_o
);

    logic [2:0] meta_q;
    logic [2:0] level_q;
    logic [2:0] prev_q;

    // ----------------------------------------------------------------
    // Per pin: meta stage feeds only the second stage
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_bit
            always_ff @(posedge ref_clk_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                begin
                    meta_q[g] <= 1'b1;
                    level_q[g] <= 1'b1;
                    prev_q[g] <= 1'b1;
                end
                else
                begin
                    meta_q[g] <= pin_i[g];
                    level_q[g] <= meta_q[g];
                    prev_q[g] <= level_q[g];
                end
            end
        end
    endgenerate

    assign level_o = level_q;
    assign prev_o = prev_q;

endmodule
`default_nettype wire

// >>> core/hold_timer.sv
// Counts cycles while a condition holds; flags once the limit is reached.
`timescale 1ns/1ps
`default_nettype none
module hold_timer
    import smbus_port_pkg::*;
#(
    parameter logic [31:0] LIMIT = 32'h10
)
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    output logic done_o
);

    logic [31:0] cnt_q;
    logic done_q;
    wire at_limit = (cnt_q >= LIMIT - 32'h1);

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_q <= TIMER_CNT_RST;
            done_q <= 1'b0;
        end
        else if (!run_i)
        begin
            cnt_q <= TIMER_CNT_RST;
            done_q <= 1'b0;
        end
        else
        begin
            // Saturate so a long hold never wraps back to zero
            if (!at_limit)
                cnt_q <= cnt_q + 32'h1;
            done_q <= at_limit;
        end
    end

    assign done_o = done_q;

endmodule
`default_nettype wire

// >>> core/smbus_target_port_cs.sv
// SMBus target port with chip select: framing, address match, write and read.
`timescale 1ns/1ps
`default_nettype none
module smbus_target_port_cs
    import smbus_port_pkg::*;
#(
    parameter logic [31:0] CLOCK_HIGH_CYCLES = CLOCK_HIGH_CYC,
    parameter logic [31:0] CLOCK_LOW_CYCLES = CLOCK_LOW_TIMEOUT_CYC
)
(
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic serial_clock_line_i,
    input wire logic sda_i,
    input wire logic port_select_i,
    input wire logic [7:0] rd_data_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic wr_strobe_o,
    output logic [7:0] wr_index_o,
    output logic [7:0] wr_data_o,
    output logic rd_strobe_o,
    output logic [7:0] rd_index_o,
    output logic bus_idle_o,
    output logic timeout_o,
    output logic port_ready_o
);

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // ----------------------------------------------------------------
    // Pin sampling and bus conditions
    // ----------------------------------------------------------------
    logic [2:0] lvl;
    logic [2:0] prv;

    pin_sync u_sync (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_q),
        .pin_i({port_select_i, sda_i, serial_clock_line_i}),
        .level_o(lvl),
        .prev_o(prv)
    );

    wire scl_s = lvl[0];
    wire scl_p = prv[0];
    wire sda_s = lvl[1];
    wire sda_p = prv[1];
    wire cs_s = lvl[2];
    wire scl_rise = scl_s & ~scl_p;
    wire scl_fall = ~scl_s & scl_p;
    wire start_w = scl_s & scl_p & sda_p & ~sda_s;
    wire stop_w = scl_s & scl_p & ~sda_p & sda_s;
    wire both_high = scl_s & sda_s;

    // ----------------------------------------------------------------
    // Bus timers
    // ----------------------------------------------------------------
    logic stop_seen_q;
    logic free_done;
    logic high_done;
    logic low_done;

    hold_timer #(.LIMIT(BUS_FREE_CYC)) u_free (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_q),
        .run_i(both_high & stop_seen_q),
        .done_o(free_done)
    );

    hold_timer #(.LIMIT(CLOCK_HIGH_CYCLES)) u_high (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_q),
        .run_i(both_high),
        .done_o(high_done)
    );

    // Runs whatever the select level, so a stuck clock is seen at once
    hold_timer #(.LIMIT(CLOCK_LOW_CYCLES)) u_low (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_q),
        .run_i(~scl_s),
        .done_o(low_done)
    );

    // ----------------------------------------------------------------
    // Transfer state
    // ----------------------------------------------------------------
    port_state_t state_q;
    port_state_t state_d;
    byte_phase_t phase_q;
    byte_phase_t phase_d;
    logic [3:0] bit_cnt_q;
    logic [3:0] bit_cnt_d;
    logic [7:0] shift_q;
    logic [7:0] shift_d;
    logic [7:0] index_q;
    logic [7:0] index_d;
    logic rd_mode_q;
    logic rd_mode_d;
    logic nack_q;
    logic nack_d;
    logic wr_fire;
    logic rd_fire;

    wire rx_byte_end = (state_q == ST_RX) & scl_fall & (bit_cnt_q == RX_LAST_CNT);
    wire addr_match = (shift_q[7:1] == TARGET_ADDR7);
    wire [7:0] index_next = index_q + INDEX_STEP;
    wire abandon = ~cs_s | low_done;

    always_comb
    begin
        state_d = state_q;
        phase_d = phase_q;
        bit_cnt_d = bit_cnt_q;
        shift_d = shift_q;
        index_d = index_q;
        rd_mode_d = rd_mode_q;
        nack_d = nack_q;
        wr_fire = 1'b0;
        rd_fire = 1'b0;
        if (abandon)
        begin
            state_d = ST_IDLE;
        end
        else if (start_w)
        begin
            // Repeated start keeps the index for the read that follows
            state_d = ST_RX;
            phase_d = PH_ADDR;
            bit_cnt_d = BIT_CNT_RST;
        end
        else if (stop_w)
        begin
            state_d = ST_IDLE;
        end
        else
        begin
            case (state_q)
                ST_RX:
                begin
                    if (scl_rise && bit_cnt_q != RX_LAST_CNT)
                    begin
                        shift_d = {shift_q[6:0], sda_s};
                        bit_cnt_d = bit_cnt_q + 4'h1;
                    end
                    if (rx_byte_end)
                    begin
                        bit_cnt_d = BIT_CNT_RST;
                        state_d = ST_ACK;
                        case (phase_q)
                            PH_ADDR:
                            begin
                                rd_mode_d = shift_q[0];
                                phase_d = PH_INDEX;
                                if (!addr_match)
                                    state_d = ST_WAIT;
                            end
                            PH_INDEX:
                            begin
                                index_d = shift_q;
                                phase_d = PH_DATA;
                            end
                            default:
                            begin
                                wr_fire = 1'b1;
                                // Further written bytes go to the following index
                                index_d = index_next;
                            end
                        endcase
                    end
                end
                ST_ACK:
                begin
                    if (scl_fall)
                    begin
                        if (rd_mode_q)
                        begin
                            shift_d = rd_data_i;
                            rd_fire = 1'b1;
                            state_d = ST_TX;
                        end
                        else
                        begin
                            state_d = ST_RX;
                        end
                    end
                end
                ST_TX:
                begin
                    if (scl_fall)
                    begin
                        if (bit_cnt_q == TX_LAST_CNT)
                        begin
                            bit_cnt_d = BIT_CNT_RST;
                            state_d = ST_RACK;
                        end
                        else
                        begin
                            shift_d = {shift_q[6:0], 1'b0};
                            bit_cnt_d = bit_cnt_q + 4'h1;
                        end
                    end
                end
                ST_RACK:
                begin
                    if (scl_rise)
                    begin
                        nack_d = sda_s;
                        // Step the index at the rise so the next byte settles before the fall
                        if (!sda_s)
                            index_d = index_next;
                    end
                    if (scl_fall)
                    begin
                        if (nack_q)
                        begin
                            state_d = ST_WAIT;
                        end
                        else
                        begin
                            // Host ack: next byte goes straight out, the slot was the host's
                            shift_d = rd_data_i;
                            rd_fire = 1'b1;
                            state_d = ST_TX;
                        end
                    end
                end
                ST_IDLE:
                begin
                    state_d = ST_IDLE;
                end
                ST_WAIT:
                begin
                    state_d = ST_WAIT;
                end
                default:
                begin
                    state_d = ST_IDLE;
                end
            endcase
        end
    end

    // The port never holds the clock, so its stretch total stays at zero.
    wire drive_low = cs_s & ((state_q == ST_ACK) | ((state_q == ST_TX) & ~shift_q[7]));

    always_ff @(posedge ref_clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            state_q <= ST_IDLE;
            phase_q <= PH_ADDR;
            bit_cnt_q <= BIT_CNT_RST;
            shift_q <= BYTE_RST;
            index_q <= BYTE_RST;
            rd_mode_q <= 1'b0;
            nack_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            phase_q <= phase_d;
            bit_cnt_q <= bit_cnt_d;
            shift_q <= shift_d;
            index_q <= index_d;
            rd_mode_q <= rd_mode_d;
            nack_q <= nack_d;
        end
    end

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    // No standby input exists here: the port runs in every power mode
    always_ff @(posedge ref_clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            sda_o <= 1'b0;
            sda_oe_o <= 1'b0;
            wr_strobe_o <= 1'b0;
            wr_index_o <= BYTE_RST;
            wr_data_o <= BYTE_RST;
            rd_strobe_o <= 1'b0;
            rd_index_o <= BYTE_RST;
            bus_idle_o <= 1'b0;
            timeout_o <= 1'b0;
            port_ready_o <= 1'b0;
            stop_seen_q <= 1'b0;
        end
        else
        begin
            sda_o <= 1'b0;
            sda_oe_o <= drive_low;
            wr_strobe_o <= wr_fire;
            if (wr_fire)
            begin
                wr_index_o <= index_q;
                wr_data_o <= shift_q;
            end
            rd_strobe_o <= rd_fire;
            rd_index_o <= index_d;
            if (start_w)
                bus_idle_o <= 1'b0;
            else if (free_done || high_done)
                bus_idle_o <= 1'b1;
            stop_seen_q <= stop_w | (stop_seen_q & ~start_w);
            timeout_o <= low_done;
            port_ready_o <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_q);

    a_deselect_quiet: assert property (!cs_s |=> !sda_oe_o)
        else $error("data driven while deselected");
    a_addr_mismatch: assert property (rx_byte_end && phase_q == PH_ADDR && !addr_match
        && cs_s && !low_done |=> state_q == ST_WAIT)
        else $error("foreign address not ignored");
    a_ack_drives: assert property (state_q == ST_ACK && cs_s |=> sda_oe_o)
        else $error("ack slot not driven low");
    a_high_stable: assert property (scl_s && scl_p && cs_s |=> $stable(sda_oe_o))
        else $error("data changed while clock high");
    a_start_frames: assert property (start_w && !abandon |=>
        state_q == ST_RX && bit_cnt_q == BIT_CNT_RST && phase_q == PH_ADDR)
        else $error("start not taken");
    a_stop_frames: assert property (stop_w && cs_s |=> state_q == ST_IDLE)
        else $error("stop not taken");
    a_idle_flag: assert property ((free_done || high_done) && !start_w |=> bus_idle_o)
        else $error("idle not flagged");
    a_timeout_abort: assert property (low_done |=> timeout_o && state_q == ST_IDLE
        ##1 !sda_oe_o)
        else $error("timeout did not abandon");
    a_write_byte: assert property (rx_byte_end && phase_q == PH_DATA && !abandon
        && !start_w && !stop_w |=> wr_strobe_o && wr_data_o == $past(shift_q))
        else $error("write byte not delivered");
    a_read_load: assert property (state_q == ST_ACK && rd_mode_q && scl_fall && !abandon
        && !start_w && !stop_w |=> state_q == ST_TX && rd_strobe_o)
        else $error("read byte not loaded");
    a_ready_soon: assert property ($rose(rst_n_q) |-> ##[0:2] port_ready_o)
        else $error("port not ready after reset");

endmodule
`default_nettype wire

// >>> testbench/smbus_host_model.sv
// Behavioural host controller with chip select driving the two-wire link.
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model
    import smbus_port_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic sda_i,
    output var logic scl_o,
    output var logic sda_oe_o,
    output var logic sel_o
);
    // ----------------------------------------------------------------
    // Line drive, one change per rising edge of the reference clock
    // ----------------------------------------------------------------
    initial
    begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
        sel_o = 1'b0;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask

    // Clock period 80 ns, low 50 ns: the target's 40 ns answer lag lands before the rise.
    // The bench scales the bus clock up; hardware runs it at 10 to 100 kHz.
    task automatic bit_xfer(input logic b, output logic s);
        wait_cyc(1);
        sda_oe_o <= ~b;
        wait_cyc(4);
        scl_o <= 1'b1;
        wait_cyc(3);
        s = sda_i;
        scl_o <= 1'b0;
    endtask

    task automatic start_cond();
        wait_cyc(4);
        sda_oe_o <= 1'b0;
        wait_cyc(4);
        scl_o <= 1'b1;
        wait_cyc(8);
        sda_oe_o <= 1'b1;
        wait_cyc(8);
        scl_o <= 1'b0;
    endtask

    task automatic stop_cond();
        wait_cyc(4);
        sda_oe_o <= 1'b1;
        wait_cyc(8);
        scl_o <= 1'b1;
        wait_cyc(8);
        sda_oe_o <= 1'b0;
        wait_cyc(int'(BUS_FREE_CYC) + 8);
    endtask

    // ----------------------------------------------------------------
    // Byte level and special line states
    // ----------------------------------------------------------------
    task automatic write_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_xfer(b[i], s);
        bit_xfer(1'b1, ack);
    endtask

    task automatic read_byte(input logic nack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_xfer(1'b1, b[i]);
        bit_xfer(nack, s);
    endtask

    // Select changes at whatever level the clock was left, away from any bit sample
    task automatic set_sel(input logic v);
        wait_cyc(1);
        sel_o <= v;
        wait_cyc(8);
    endtask

    task automatic hold_low(input int n);
        wait_cyc(n);
    endtask

    // Raises the clock with data released, so no stop edge is made
    task automatic release_high(input int n);
        wait_cyc(4);
        sda_oe_o <= 1'b0;
        wait_cyc(8);
        scl_o <= 1'b1;
        wait_cyc(n);
    endtask
endmodule
`default_nettype wire

// >>> testbench/smbus_target_port_cs_tb.sv
// Self-checking bench: host model, register model and the target port.
`timescale 1ns/1ps
`default_nettype none
module smbus_target_port_cs_tb
    import smbus_port_pkg::*;
    ;
    localparam logic [31:0] LOW_CYC = 32'h7D0;
    localparam logic [31:0] HIGH_CYC = 32'h258;
    logic ref_clk;
    logic rst_b;
    wire logic scl;
    wire logic host_oe;
    wire logic sel;
    wire logic sda_w;
    wire logic [7:0] rd_data;
    logic sda_o, sda_oe, wr_strobe, rd_strobe, bus_idle, timeout, port_ready;
    logic [7:0] wr_index, wr_data, rd_index;
    logic oe_prev, scl_prev;
    logic [7:0] user_mem [256];
    logic [7:0] exp_mem [256];
    logic [15:0] exp_q [$];
    int fail_count = 0;
    int n_checks = 0;
    int wr_cnt = 0, wr_exp = 0, rd_cnt = 0, rd_exp = 0, oe_cnt = 0, glitch = 0, cyc = 0;

    // ----------------------------------------------------------------
    // Instances and wire
    // ----------------------------------------------------------------
    assign sda_w = ~(host_oe | sda_oe);
    assign rd_data = user_mem[rd_index];

    smbus_host_model host (.ref_clk_i(ref_clk), .sda_i(sda_w), .scl_o(scl),
        .sda_oe_o(host_oe), .sel_o(sel));

    smbus_target_port_cs #(.CLOCK_HIGH_CYCLES(HIGH_CYC), .CLOCK_LOW_CYCLES(LOW_CYC))
        smbus_target_port_cs_inst (.ref_clk_i(ref_clk), .rst_b_i(rst_b),
        .serial_clock_line_i(scl), .sda_i(sda_w), .port_select_i(sel), .rd_data_i(rd_data),
        .sda_o(sda_o), .sda_oe_o(sda_oe), .wr_strobe_o(wr_strobe), .wr_index_o(wr_index),
        .wr_data_o(wr_data), .rd_strobe_o(rd_strobe), .rd_index_o(rd_index),
        .bus_idle_o(bus_idle), .timeout_o(timeout), .port_ready_o(port_ready));

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ----------------------------------------------------------------
    // Checking and monitors
    // ----------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // User side register file; a strobe with nothing queued shows up in the counts
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        oe_prev <= sda_oe;
        scl_prev <= scl;
        if (sda_oe === 1'b1)
            oe_cnt <= oe_cnt + 1;
        // Gated by ready so the unknown before reset is not counted as a change
        if (port_ready === 1'b1 && scl === 1'b1 && scl_prev === 1'b1 && sda_oe !== oe_prev)
            glitch <= glitch + 1;
        if (rd_strobe === 1'b1)
            rd_cnt <= rd_cnt + 1;
        if (wr_strobe === 1'b1)
        begin
            wr_cnt <= wr_cnt + 1;
            user_mem[wr_index] <= wr_data;
            if (exp_q.size() > 0)
                check({wr_index, wr_data}, exp_q.pop_front());
        end
        if (cyc == 40000)
        begin
            fail_count++;
            finish_test();
        end
    end

    // ----------------------------------------------------------------
    // Transactions
    // ----------------------------------------------------------------
    task automatic check_ack(input logic a, input logic ok);
        check({15'h0000, a}, {15'h0000, ~ok});
    endtask

    task automatic wr_txn(input logic [7:0] addr, input logic [7:0] idx, input logic [7:0] d,
        input logic ok);
        logic a;
        host.start_cond();
        host.write_byte(addr, a);
        check_ack(a, ok);
        host.write_byte(idx, a);
        check_ack(a, ok);
        if (ok)
        begin
            exp_q.push_back({idx, d});
            exp_mem[idx] = d;
            wr_exp++;
        end
        host.write_byte(d, a);
        check_ack(a, ok);
        host.stop_cond();
        check({15'h0000, bus_idle}, 16'h0001);
        check(16'(wr_cnt), 16'(wr_exp));
    endtask

    task automatic rd_txn(input logic [7:0] idx);
        logic a;
        logic [7:0] b;
        host.start_cond();
        check({15'h0000, bus_idle}, 16'h0000);
        host.write_byte(TARGET_ADDR_WRITE_BYTE, a);
        check_ack(a, 1'b1);
        host.write_byte(idx, a);
        check_ack(a, 1'b1);
        host.start_cond();
        host.write_byte(TARGET_ADDR_WRITE_BYTE | 8'h01, a);
        check_ack(a, 1'b1);
        host.read_byte(1'b1, b);
        check({8'h00, b}, {8'h00, exp_mem[idx]});
        host.stop_cond();
        rd_exp++;
        check(16'(rd_cnt), 16'(rd_exp));
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        logic a;
        logic [7:0] v;
        logic [7:0] idx [3];
        int oe_base;
        rst_b = 1'b0;
        void'($urandom(32'h369D));
        for (int i = 0; i < 256; i++)
        begin
            v = 8'($urandom);
            user_mem[i] = v;
            exp_mem[i] = v;
        end
        repeat (10) @(posedge ref_clk);
        check({13'h0000, sda_oe, wr_strobe, port_ready}, 16'h0000);
        rst_b <= 1'b1;
        repeat (8) @(posedge ref_clk);
        check({15'h0000, port_ready}, 16'h0001);
        host.set_sel(1'b1);
        for (int i = 0; i < 3; i++)
        begin
            idx[i] = 8'($urandom);
            wr_txn(TARGET_ADDR_WRITE_BYTE, idx[i], 8'($urandom), 1'b1);
        end
        for (int i = 2; i >= 0; i--)
            rd_txn(idx[i]);
        $display("test write and read done");
        for (int i = 0; i < 3; i++)
            wr_txn(TARGET_ADDR_WRITE_BYTE ^ (8'h02 << ($urandom % 7)), 8'($urandom),
                8'($urandom), 1'b0);
        $display("test foreign address done");
        oe_base = oe_cnt;
        host.set_sel(1'b0);
        wr_txn(TARGET_ADDR_WRITE_BYTE, idx[0], 8'($urandom), 1'b0);
        check(16'(oe_cnt - oe_base), 16'h0000);
        host.set_sel(1'b1);
        host.start_cond();
        host.write_byte(TARGET_ADDR_WRITE_BYTE, a);
        check_ack(a, 1'b1);
        host.write_byte(idx[1], a);
        host.set_sel(1'b0);
        host.write_byte(8'($urandom), a);
        check_ack(a, 1'b0);
        host.stop_cond();
        host.set_sel(1'b1);
        check(16'(wr_cnt), 16'(wr_exp));
        $display("test deselect done");
        host.start_cond();
        host.write_byte(TARGET_ADDR_WRITE_BYTE, a);
        host.write_byte(idx[2], a);
        host.hold_low(int'(LOW_CYC) + 100);
        check({15'h0000, timeout}, 16'h0001);
        host.write_byte(8'($urandom), a);
        check_ack(a, 1'b0);
        host.release_high(int'(HIGH_CYC) + 40);
        check({15'h0000, bus_idle}, 16'h0001);
        check(16'(wr_cnt), 16'(wr_exp));
        wr_txn(TARGET_ADDR_WRITE_BYTE, idx[2], 8'($urandom), 1'b1);
        rd_txn(idx[2]);
        rd_txn(idx[0]);
        check(16'(glitch), 16'h0000);
        check({15'h0000, sda_o}, 16'h0000);
        $display("test timeout and recovery done");
        finish_test();
    end
endmodule
`default_nettype wire
